/* File: xcvr_reconfig_consts.svh */
`ifndef XCVR_RECONFIG_CONSTS_SVH
`define XCVR_RECONFIG_CONSTS_SVH

// ==========================================================
// receive video standard codes
`define STD_SD 2'h0
`define STD_HD 2'h1
`define STD_3G 2'h2
`define STD_3G_LEVEL_A 2'h3
`define STD_3G_LEVEL_B 2'h2

// ==========================================================
// link widths
`define TO_XCVR_W 4
`define FROM_XCVR_W 17
`define SCAN_LEN 32
`define SCAN_CNT_W 6
`define SCAN_LEN_CNT 6'h20

// ==========================================================
// timing counts, in MCLK_I cycles
`define SCAN_DONE_CYC 8'h10
`define SCAN_DIV 2'h3
`define XCVR_HOLD_CYC 4'h4
`define ARESET_CYC 4'h4

// ==========================================================
// controller register map, byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_XCVR_CODES 8'h08
`define ADDR_PLL_CFG0 8'h0C
`define ADDR_PLL_CFG1 8'h10
`define ADDR_PLL_CFG2 8'h14
`define ADDR_PLL_CFG3 8'h18
`define ADDR_FROM_XCVR 8'h1C

// ==========================================================
// control fields and reset values
`define CTRL_ENABLE_BIT 0
`define CTRL_PLL_MODE_BIT 1
`define CTRL_POWER_DOWN_BIT 2
`define CTRL_RST 3'h0
`define XCVR_CODES_RST 16'h3210
`define PLL_CFG_RST 32'h00000000

`endif

/* File: xcvr_reconfig_pkg.sv */
package xcvr_reconfig_pkg;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_REQ = 2'b01,
    S_RELEASE = 2'b10
  } req_state_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_XCVR = 3'b001,
    C_PLL_RST = 3'b010,
    C_PLL_SHIFT = 3'b011,
    C_PLL_UPD = 3'b100,
    C_PLL_WAIT = 3'b101,
    C_DONE = 3'b110
  } ctl_state_t;

endpackage

/* File: xcvr_reconfig_if.sv */
`timescale 1ns/1ps
interface xcvr_reconfig_if;
  logic reconfig_request;
  logic reconfig_finished;
  logic [3:0] reconfig_bus_to_xcvr;
  logic [16:0] reconfig_bus_from_xcvr;
  logic xcvr_power_down;
  logic [1:0] rx_standard;
  logic pll_reset;
  logic pll_update;
  logic pll_scan_clock;
  logic pll_scan_clock_gate;
  logic pll_scan_serial_in;
  logic pll_scan_complete;
  logic pll_scan_serial_out;

  modport dev (
    output reconfig_request,
    input reconfig_finished,
    input reconfig_bus_to_xcvr,
    output reconfig_bus_from_xcvr,
    input xcvr_power_down,
    output rx_standard,
    input pll_reset,
    input pll_update,
    input pll_scan_clock,
    input pll_scan_clock_gate,
    input pll_scan_serial_in,
    output pll_scan_complete,
    output pll_scan_serial_out
  );

  modport ctl (
    input reconfig_request,
    output reconfig_finished,
    output reconfig_bus_to_xcvr,
    input reconfig_bus_from_xcvr,
    output xcvr_power_down,
    input rx_standard,
    output pll_reset,
    output pll_update,
    output pll_scan_clock,
    output pll_scan_clock_gate,
    output pll_scan_serial_in,
    input pll_scan_complete,
    input pll_scan_serial_out
  );
endinterface

/* File: reconfig_device_end.sv */
`timescale 1ns/1ps
`include "xcvr_reconfig_consts.svh"
module reconfig_device_end
  import xcvr_reconfig_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  xcvr_reconfig_if.dev LINK,
  input wire logic [1:0] RX_STD_DET_I,
  input wire logic RX_LEVEL_A_I,
  input wire logic RX_STD_VALID_I,
  input wire logic PLL_MODE_I,
  output logic RECONFIG_BUSY_O,
  output logic [1:0] ACTIVE_STD_O,
  output logic [3:0] XCVR_CFG_O,
  output logic [31:0] PLL_CFG_O,
  output logic XCVR_RESET_O
);

  // ==========================================================
  // state
  req_state_t state_reg;
  logic request_reg;
  logic busy_reg;
  logic [1:0] rx_std_reg;
  logic [1:0] std_next;
  logic [1:0] target_std_reg;
  logic [1:0] active_std_reg;
  logic [3:0] xcvr_cfg_reg;
  logic [16:0] from_xcvr_reg;
  logic pd_reg;
  logic scan_clk_prev_reg;
  logic update_prev_reg;
  logic [31:0] scan_chain_reg;
  logic [31:0] pll_cfg_reg;
  logic scan_out_reg;
  logic [7:0] done_cnt_reg;
  logic scan_complete_reg;
  logic scan_complete_prev_reg;
  logic finish_evt;
  logic pd;

  assign pd = LINK.xcvr_power_down;

  // ==========================================================
  // standard coding
  always_comb
  begin
    if (RX_STD_DET_I == `STD_3G)
    begin
      std_next = RX_LEVEL_A_I ? `STD_3G_LEVEL_A : `STD_3G_LEVEL_B;
    end
    else
    begin
      std_next = RX_STD_DET_I;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rx_std_reg <= `STD_SD;
    end
    else if (pd)
    begin
      rx_std_reg <= `STD_SD;
    end
    else if (RX_STD_VALID_I)
    begin
      rx_std_reg <= std_next;
    end
  end

  // ==========================================================
  // request handshake
  // pll path finishes on the scan done rising edge, never on the finished input
  assign finish_evt = PLL_MODE_I ? (scan_complete_reg && !scan_complete_prev_reg)
                                 : LINK.reconfig_finished;

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_reg <= S_IDLE;
      request_reg <= 1'b0;
      target_std_reg <= `STD_SD;
      active_std_reg <= `STD_SD;
    end
    else if (pd)
    begin
      // after power-down the active setting is unknown, so assume SD again
      state_reg <= S_IDLE;
      request_reg <= 1'b0;
      target_std_reg <= `STD_SD;
      active_std_reg <= `STD_SD;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (RX_STD_VALID_I && (rx_std_reg != active_std_reg))
          begin
            request_reg <= 1'b1;
            target_std_reg <= rx_std_reg;
            state_reg <= S_REQ;
          end
        end
        S_REQ:
        begin
          if (finish_evt)
          begin
            request_reg <= 1'b0;
            active_std_reg <= target_std_reg;
            state_reg <= S_RELEASE;
          end
        end
        S_RELEASE:
        begin
          // outside pll mode, wait for finished to drop so one answer is not taken twice
          if (PLL_MODE_I || !LINK.reconfig_finished)
          begin
            state_reg <= S_IDLE;
          end
        end
        default:
        begin
          state_reg <= S_IDLE;
          request_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      busy_reg <= 1'b0;
      pd_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= (state_reg != S_IDLE) && !pd;
      pd_reg <= pd;
    end
  end

  // ==========================================================
  // transceiver reconfiguration data port
  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      xcvr_cfg_reg <= 4'h0;
      from_xcvr_reg <= 17'h00000;
    end
    else if (pd)
    begin
      xcvr_cfg_reg <= 4'h0;
      from_xcvr_reg <= 17'h00000;
    end
    else
    begin
      if ((state_reg == S_REQ) && !PLL_MODE_I && LINK.reconfig_finished)
      begin
        xcvr_cfg_reg <= LINK.reconfig_bus_to_xcvr;
      end
      from_xcvr_reg <= {8'h00, xcvr_cfg_reg, rx_std_reg, active_std_reg, request_reg};
    end
  end

  // ==========================================================
  // pll scan chain
  // scan clock is sampled by MCLK_I, so it must run well below MCLK_I
  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      scan_clk_prev_reg <= 1'b0;
      scan_chain_reg <= 32'h00000000;
      scan_out_reg <= 1'b0;
    end
    else
    begin
      scan_clk_prev_reg <= LINK.pll_scan_clock;
      if (LINK.pll_scan_clock && !scan_clk_prev_reg && LINK.pll_scan_clock_gate)
      begin
        scan_chain_reg <= {scan_chain_reg[30:0], LINK.pll_scan_serial_in};
        scan_out_reg <= scan_chain_reg[31];
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      update_prev_reg <= 1'b0;
      pll_cfg_reg <= 32'h00000000;
      done_cnt_reg <= 8'h00;
      scan_complete_reg <= 1'b0;
      scan_complete_prev_reg <= 1'b0;
    end
    else
    begin
      update_prev_reg <= LINK.pll_update;
      scan_complete_prev_reg <= scan_complete_reg;
      if (LINK.pll_reset)
      begin
        // pll reset drops the done indication and aborts a pending update
        done_cnt_reg <= 8'h00;
        scan_complete_reg <= 1'b0;
      end
      else if (LINK.pll_update && !update_prev_reg)
      begin
        pll_cfg_reg <= scan_chain_reg;
        done_cnt_reg <= `SCAN_DONE_CYC;
        scan_complete_reg <= 1'b0;
      end
      else if (done_cnt_reg != 8'h00)
      begin
        done_cnt_reg <= done_cnt_reg - 8'h01;
        if (done_cnt_reg == 8'h01)
        begin
          scan_complete_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // outputs
  assign LINK.reconfig_request = request_reg;
  assign LINK.rx_standard = rx_std_reg;
  assign LINK.reconfig_bus_from_xcvr = from_xcvr_reg;
  assign LINK.pll_scan_complete = scan_complete_reg;
  assign LINK.pll_scan_serial_out = scan_out_reg;
  assign RECONFIG_BUSY_O = busy_reg;
  assign ACTIVE_STD_O = active_std_reg;
  assign XCVR_CFG_O = xcvr_cfg_reg;
  assign PLL_CFG_O = pll_cfg_reg;
  assign XCVR_RESET_O = pd_reg;

endmodule

/* File: reconfig_ctrl_end.sv */
`timescale 1ns/1ps
`include "xcvr_reconfig_consts.svh"
module reconfig_ctrl_end
  import xcvr_reconfig_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  xcvr_reconfig_if.ctl LINK
);

  // ==========================================================
  // registers
  ctl_state_t state_reg;
  logic [2:0] ctrl_reg;
  logic [15:0] codes_reg;
  logic [31:0] pll_cfg_mem [0:3];
  logic [7:0] count_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] rd_mux;
  logic rd_err;
  logic wr_en;
  logic [1:0] std_reg;
  logic [3:0] cnt_reg;
  logic [1:0] div_reg;
  logic [31:0] shift_reg;
  logic [5:0] bits_reg;
  logic finished_reg;
  logic [3:0] to_xcvr_reg;
  logic pll_reset_reg;
  logic pll_update_reg;
  logic scan_clk_reg;
  logic scan_gate_reg;
  logic scan_data_reg;
  logic tick;

  // ==========================================================
  // apb slave, one wait-free access phase
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && pready_reg;

  always_comb
  begin
    rd_err = 1'b0;
    case (PADDR_I)
      `ADDR_CTRL: rd_mux = {29'h0, ctrl_reg};
      `ADDR_STATUS: rd_mux = {16'h0, count_reg, 3'h0, finished_reg,
                              (state_reg != C_IDLE), LINK.reconfig_request, LINK.rx_standard};
      `ADDR_XCVR_CODES: rd_mux = {16'h0, codes_reg};
      `ADDR_PLL_CFG0: rd_mux = pll_cfg_mem[0];
      `ADDR_PLL_CFG1: rd_mux = pll_cfg_mem[1];
      `ADDR_PLL_CFG2: rd_mux = pll_cfg_mem[2];
      `ADDR_PLL_CFG3: rd_mux = pll_cfg_mem[3];
      `ADDR_FROM_XCVR: rd_mux = {15'h0, LINK.reconfig_bus_from_xcvr};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= PSEL_I && !PENABLE_I;
      if (PSEL_I && !PENABLE_I)
      begin
        prdata_reg <= PWRITE_I ? 32'h00000000 : rd_mux;
        pslverr_reg <= rd_err;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ctrl_reg <= `CTRL_RST;
      codes_reg <= `XCVR_CODES_RST;
      pll_cfg_mem[0] <= `PLL_CFG_RST;
      pll_cfg_mem[1] <= `PLL_CFG_RST;
      pll_cfg_mem[2] <= `PLL_CFG_RST;
      pll_cfg_mem[3] <= `PLL_CFG_RST;
    end
    else if (wr_en)
    begin
      case (PADDR_I)
        `ADDR_CTRL: ctrl_reg <= PWDATA_I[2:0];
        `ADDR_XCVR_CODES: codes_reg <= PWDATA_I[15:0];
        `ADDR_PLL_CFG0: pll_cfg_mem[0] <= PWDATA_I;
        `ADDR_PLL_CFG1: pll_cfg_mem[1] <= PWDATA_I;
        `ADDR_PLL_CFG2: pll_cfg_mem[2] <= PWDATA_I;
        `ADDR_PLL_CFG3: pll_cfg_mem[3] <= PWDATA_I;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ==========================================================
  // scan clock divider, free only while shifting
  assign tick = (div_reg == `SCAN_DIV);

  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      div_reg <= 2'h0;
    end
    else if (state_reg == C_PLL_SHIFT)
    begin
      div_reg <= div_reg + 2'h1;
    end
    else
    begin
      div_reg <= 2'h0;
    end
  end

  // ==========================================================
  // reconfiguration sequencer
  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_reg <= C_IDLE;
      std_reg <= `STD_SD;
      cnt_reg <= 4'h0;
      shift_reg <= 32'h00000000;
      bits_reg <= 6'h00;
      finished_reg <= 1'b0;
      to_xcvr_reg <= 4'h0;
      pll_reset_reg <= 1'b0;
      pll_update_reg <= 1'b0;
      scan_clk_reg <= 1'b0;
      scan_gate_reg <= 1'b0;
      scan_data_reg <= 1'b0;
      count_reg <= 8'h00;
    end
    else
    begin
      pll_update_reg <= 1'b0;
      case (state_reg)
        C_IDLE:
        begin
          if (ctrl_reg[`CTRL_ENABLE_BIT] && LINK.reconfig_request)
          begin
            std_reg <= LINK.rx_standard;
            if (ctrl_reg[`CTRL_PLL_MODE_BIT])
            begin
              pll_reset_reg <= 1'b1;
              cnt_reg <= `ARESET_CYC;
              state_reg <= C_PLL_RST;
            end
            else
            begin
              to_xcvr_reg <= codes_reg[{LINK.rx_standard, 2'b00} +: 4];
              cnt_reg <= `XCVR_HOLD_CYC;
              state_reg <= C_XCVR;
            end
          end
        end
        C_XCVR:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1)
          begin
            finished_reg <= 1'b1;
            state_reg <= C_DONE;
          end
        end
        C_PLL_RST:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1)
          begin
            pll_reset_reg <= 1'b0;
            shift_reg <= pll_cfg_mem[std_reg];
            scan_data_reg <= pll_cfg_mem[std_reg][31];
            bits_reg <= `SCAN_LEN_CNT;
            scan_gate_reg <= 1'b1;
            state_reg <= C_PLL_SHIFT;
          end
        end
        C_PLL_SHIFT:
        begin
          if (tick && !scan_clk_reg)
          begin
            scan_clk_reg <= 1'b1;
            bits_reg <= bits_reg - 6'h01;
          end
          else if (tick)
          begin
            scan_clk_reg <= 1'b0;
            if (bits_reg == 6'h00)
            begin
              scan_gate_reg <= 1'b0;
              state_reg <= C_PLL_UPD;
            end
            else
            begin
              shift_reg <= {shift_reg[30:0], 1'b0};
              scan_data_reg <= shift_reg[30];
            end
          end
        end
        C_PLL_UPD:
        begin
          pll_update_reg <= 1'b1;
          state_reg <= C_PLL_WAIT;
        end
        C_PLL_WAIT:
        begin
          if (LINK.pll_scan_complete)
          begin
            finished_reg <= 1'b1;
            state_reg <= C_DONE;
          end
        end
        C_DONE:
        begin
          if (!LINK.reconfig_request)
          begin
            finished_reg <= 1'b0;
            count_reg <= count_reg + 8'h01;
            state_reg <= C_IDLE;
          end
        end
        default:
        begin
          state_reg <= C_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      LINK.xcvr_power_down <= 1'b0;
    end
    else
    begin
      LINK.xcvr_power_down <= ctrl_reg[`CTRL_POWER_DOWN_BIT];
    end
  end

  assign LINK.reconfig_finished = finished_reg;
  assign LINK.reconfig_bus_to_xcvr = to_xcvr_reg;
  assign LINK.pll_reset = pll_reset_reg;
  assign LINK.pll_update = pll_update_reg;
  assign LINK.pll_scan_clock = scan_clk_reg;
  assign LINK.pll_scan_clock_gate = scan_gate_reg;
  assign LINK.pll_scan_serial_in = scan_data_reg;
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;

endmodule

/* File: xcvr_reconfig_checker.sv */
`timescale 1ns/1ps
module xcvr_reconfig_checker (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic reconfig_request,
  input wire logic reconfig_finished,
  input wire logic [3:0] reconfig_bus_to_xcvr,
  input wire logic [16:0] reconfig_bus_from_xcvr,
  input wire logic xcvr_power_down,
  input wire logic [1:0] rx_standard,
  input wire logic pll_reset,
  input wire logic pll_update,
  input wire logic pll_scan_clock,
  input wire logic pll_scan_clock_gate,
  input wire logic pll_scan_serial_in,
  input wire logic pll_scan_complete,
  input wire logic pll_scan_serial_out
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // ==========================================================
  // request and finished handshake
  // only finished, the rise of scan complete or power-down ends a request, a stale high level must not
  req_hold_a: assert property (reconfig_request && !reconfig_finished
    && !$rose(pll_scan_complete) && !xcvr_power_down |=> reconfig_request)
    else $error("request dropped early");
  req_drop_a: assert property (reconfig_request && reconfig_finished |=> !reconfig_request)
    else $error("request held after finished");
  fin_hold_a: assert property (reconfig_finished && reconfig_request |=> reconfig_finished)
    else $error("finished dropped while request high");
  no_early_a: assert property ($rose(reconfig_request) |-> !reconfig_finished)
    else $error("new request while finished high");
  pd_clear_a: assert property (xcvr_power_down |=> !reconfig_request && rx_standard == 2'b00)
    else $error("power down did not clear device");
  from_pad_a: assert property (reconfig_bus_from_xcvr[16:9] == 8'h00)
    else $error("return bus upper bits not zero");
  bus_stable_a: assert property (reconfig_finished |-> $stable(reconfig_bus_to_xcvr))
    else $error("transceiver bus moved while finished");

  // ==========================================================
  // pll scan path
  done_time_a: assert property (pll_update && !pll_reset |-> ##[15:17] pll_scan_complete)
    else $error("scan complete late");
  done_clr_a: assert property (pll_reset |=> !pll_scan_complete)
    else $error("scan complete survived pll reset");
  // data may only move on the scan clock fall, so it is settled when the rise is seen
  scan_data_a: assert property ($rose(pll_scan_clock) |-> $stable(pll_scan_serial_in))
    else $error("scan data moved at scan clock rise");
  // a gated-off scan clock must leave the chain untouched
  scan_hold_a: assert property (!pll_scan_clock_gate && !$past(pll_scan_clock_gate)
    && !xcvr_power_down |=> $stable(pll_scan_serial_out)) else $error("scan out moved ungated");

  cover property ($fell(reconfig_request));
  cover property (pll_update);
  cover property (xcvr_power_down);
endmodule

/* File: tb_xcvr_reconfig_handshake.sv */
`timescale 1ns/1ps
module tb_xcvr_reconfig_handshake;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] det = 2'h0;
  logic lvl = 1'b0;
  logic valid = 1'b0;
  logic pll_mode = 1'b0;
  logic busy;
  logic [1:0] act_std;
  logic [3:0] xcfg;
  logic [31:0] pcfg;
  logic xrst;
  int err_count = 0;
  int comparisons = 0;
  integer seed = 32'h73B6;
  logic [31:0] codes;
  logic [31:0] pll_cfg [4];
  logic [3:0] cur_cfg = 4'h0;
  logic [31:0] chain = 32'h0;
  int done_cnt = 0;
  int stds[$] = '{2, 0, 1};
  logic [31:0] rd;
  logic er;

  always #12.5 clk = ~clk;

  // ==========================================================
  // two ends joined by the link
  xcvr_reconfig_if link_if();
  reconfig_device_end reconfig_device_end_inst (.MCLK_I(clk), .RESET_N_I(rst_n), .LINK(link_if),
    .RX_STD_DET_I(det), .RX_LEVEL_A_I(lvl), .RX_STD_VALID_I(valid), .PLL_MODE_I(pll_mode),
    .RECONFIG_BUSY_O(busy), .ACTIVE_STD_O(act_std), .XCVR_CFG_O(xcfg), .PLL_CFG_O(pcfg),
    .XCVR_RESET_O(xrst));
  reconfig_ctrl_end reconfig_ctrl_end_inst (.MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK(link_if));
  xcvr_reconfig_checker xcvr_reconfig_checker_inst (.MCLK_I(clk), .RESET_N_I(rst_n),
    .reconfig_request(link_if.reconfig_request), .reconfig_finished(link_if.reconfig_finished),
    .reconfig_bus_to_xcvr(link_if.reconfig_bus_to_xcvr),
    .reconfig_bus_from_xcvr(link_if.reconfig_bus_from_xcvr),
    .xcvr_power_down(link_if.xcvr_power_down), .rx_standard(link_if.rx_standard),
    .pll_reset(link_if.pll_reset), .pll_update(link_if.pll_update),
    .pll_scan_clock(link_if.pll_scan_clock), .pll_scan_clock_gate(link_if.pll_scan_clock_gate),
    .pll_scan_serial_in(link_if.pll_scan_serial_in),
    .pll_scan_complete(link_if.pll_scan_complete),
    .pll_scan_serial_out(link_if.pll_scan_serial_out));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one idle cycle before each setup keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(n < 3000), 32'h1);
  endtask

  // code 3 is 3G level A, so the detector sees 3G with the level flag set
  task automatic run(input int c);
    @(posedge clk);
    det <= (c == 3) ? 2'h2 : c[1:0];
    lvl <= (c == 3);
    valid <= 1'b1;
    wait_done();
    repeat (4) @(posedge clk);
    check(act_std, c);
    check(link_if.rx_standard, c);
    if (!pll_mode)
      cur_cfg = codes[4*c +: 4];
    else
    begin
      check(pcfg, pll_cfg[c]);
      // the last bit shifted out is bit 0 of the word loaded before
      check(link_if.pll_scan_serial_out, chain[0]);
      chain = pll_cfg[c];
    end
    check(xcfg, cur_cfg);
    done_cnt++;
    rdchk(8'h04, {16'h0, 8'(done_cnt), 6'h0, 2'(c)});
    rdchk(8'h1C, {23'h0, cur_cfg, 2'(c), 2'(c), 1'b0});
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    codes = $random(seed);
    for (int i = 0; i < 4; i++)
      pll_cfg[i] = $random(seed);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h08, 32'h3210);
    rdchk(8'h00, 32'h0);
    rdchk(8'h0C, 32'h0);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    check(er, 1'b1);
    rdchk(8'h20, 32'h0);
    apb(1'b1, 8'h08, codes);
    check(er, 1'b0);
    rdchk(8'h08, codes & 32'hFFFF);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'(12 + 4 * i), pll_cfg[i]);
      rdchk(8'(12 + 4 * i), pll_cfg[i]);
    end
    // controller disabled: the request must stand unanswered
    @(posedge clk);
    det <= 2'h1;
    valid <= 1'b1;
    repeat (30) @(posedge clk);
    check(link_if.reconfig_finished, 1'b0);
    check(link_if.reconfig_request, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    run(1);
    // a change seen while the standard is not valid is not acted on
    @(posedge clk);
    valid <= 1'b0;
    det <= 2'h2;
    repeat (20) @(posedge clk);
    check(busy, 1'b0);
    run(3);
    foreach (stds[k])
      run(stds[k]);
    apb(1'b1, 8'h00, 32'h3);
    pll_mode <= 1'b1;
    run(0);
    run(3);
    apb(1'b1, 8'h00, 32'h5);
    pll_mode <= 1'b0;
    repeat (3) @(posedge clk);
    check(xrst, 1'b1);
    check(act_std, 2'h0);
    check(link_if.rx_standard, 2'h0);
    check(xcfg, 4'h0);
    apb(1'b1, 8'h00, 32'h1);
    run(3);
    check(xrst, 1'b0);
    conclude();
  end

  // about 45 times the expected run length
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
